// ### dsb_pkg.sv
// shared constants and types for the burst sram core
package dsb_pkg;
    localparam int DQ_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int ADDR_W = 20;
    localparam int FIFO_DEPTH = 16;
    localparam int BURST_LEN = 4;
    localparam logic [1:0] LAST_BEAT = 2'h3;
    localparam logic [1:0] FIRST_BEAT = 2'h0;
    localparam logic [1:0] SECOND_BEAT = 2'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WRITE = 3'h2,
        ST_READ = 3'h4
    } dsb_state_t;
endpackage

// ### dsb_fifo.sv
// synchronous valid/ready fifo with flip-flop storage
`timescale 1ns/1ns
`default_nettype none
module dsb_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic push;
    logic pop;

    assign o_ready = (count_ff != DEPTH[PW:0]);
    assign o_valid = (count_ff != '0);
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;
    assign o_data = mem_ff[rd_ptr_ff];

    always_ff @(posedge I_CLK) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_data;
        end
    end

    // pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### dsb_sram_core.sv
// bus-cycle, burst and byte-write logic of a ddr burst-of-four sram
// Behaviour
// R1: both lane masks low on a write beat store all eighteen bits.
// R2: lane 0 mask low writes bits 0-8, lane 1 mask low bits 9-17.
// R3: masks are sampled separately with every write beat of a burst.
// R4: masks only matter during a write burst.
// R5: two low burst address bits are generated internally per word.
// R6: bus cycle ends by itself after four words.
// R7: load low starts a cycle; load high is an idle transition.
// R8: read/write select high loads a read, low loads a write.
// R9: the bus-cycle state machine advances only on true input clock rises.
// R10: burst order is linear, wrapping within an aligned group of four.
// R11: controller gives write beats on K(t+1), K#(t+1), K(t+2), K#(t+2).
// R12: read beats go out on C#(t+1), C(t+2), C#(t+2), C(t+3).
// R13: read data follows output clocks, or input clocks when both are high.
`timescale 1ns/1ns
`default_nettype none
module dsb_sram_core #(
    parameter int ADDR_W = dsb_pkg::ADDR_W,
    parameter int FIFO_DEPTH = dsb_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // sampled clock pins
    input wire logic I_K,
    input wire logic I_K_N,
    input wire logic I_C,
    input wire logic I_C_N,
    // control and address
    input wire logic I_CYCLE_LOAD_N,
    input wire logic I_READ_WRITE,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic I_LANE0_WRITE_MASK_N,
    input wire logic I_LANE1_WRITE_MASK_N,
    // data bus, split into its three signals
    input wire logic [dsb_pkg::DQ_W-1:0] I_DQ,
    output logic [dsb_pkg::DQ_W-1:0] O_DQ,
    output logic O_DQ_OE,
    // write buffer status
    output logic O_WRITE_READY
);
    localparam int DQ_W = dsb_pkg::DQ_W;
    localparam int LANE_W = dsb_pkg::LANE_W;
    localparam int LANES = dsb_pkg::LANES;
    localparam int FW = ADDR_W + DQ_W + LANES;

    ////////////////////////////////////////////////////////////////////////
    // clock edge detection
    logic k_prev_ff;
    logic kn_prev_ff;
    logic ot_prev_ff;
    logic oc_prev_ff;
    logic out_bypass;
    logic out_true;
    logic out_comp;
    logic k_rise;
    logic kn_rise;
    logic ot_rise;
    logic oc_rise;

    assign out_bypass = I_C & I_C_N; // [R13]
    assign out_true = out_bypass ? I_K : I_C; // [R13]
    assign out_comp = out_bypass ? I_K_N : I_C_N; // [R13]
    assign k_rise = I_K & ~k_prev_ff;
    assign kn_rise = I_K_N & ~kn_prev_ff;
    assign ot_rise = out_true & ~ot_prev_ff;
    assign oc_rise = out_comp & ~oc_prev_ff;

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            k_prev_ff <= 1'b1;
            kn_prev_ff <= 1'b1;
            ot_prev_ff <= 1'b1;
            oc_prev_ff <= 1'b1;
        end else begin
            k_prev_ff <= I_K;
            kn_prev_ff <= I_K_N;
            ot_prev_ff <= out_true;
            oc_prev_ff <= out_comp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus-cycle state machine
    dsb_pkg::dsb_state_t state_ff;
    dsb_pkg::dsb_state_t nxt_state;
    logic half_ff;
    logic accept;
    logic load_wr;
    logic load_rd;

    // a cycle spans two true clocks; a load in its first clock is ignored
    assign accept = k_rise & ((state_ff == dsb_pkg::ST_IDLE) | half_ff); // [R9]
    assign load_wr = accept & ~I_CYCLE_LOAD_N & ~I_READ_WRITE; // [R7] [R8]
    assign load_rd = accept & ~I_CYCLE_LOAD_N & I_READ_WRITE; // [R7] [R8]

    always_comb begin
        nxt_state = state_ff;
        if (accept) begin
            if (I_CYCLE_LOAD_N) begin
                nxt_state = dsb_pkg::ST_IDLE; // [R7]
            end else begin
                nxt_state = I_READ_WRITE ? dsb_pkg::ST_READ : dsb_pkg::ST_WRITE; // [R8]
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_ff <= dsb_pkg::ST_IDLE;
            half_ff <= 1'b0;
        end else if (k_rise) begin // [R9]
            state_ff <= nxt_state;
            half_ff <= accept ? 1'b0 : 1'b1; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write beat engine
    logic w_go_ff;
    logic w_act_ff;
    logic [1:0] w_cnt_ff;
    logic [ADDR_W-1:0] w_load_ff;
    logic [ADDR_W-1:0] w_base_ff;
    logic w_start;
    logic w_beat;
    logic [1:0] w_idx;
    logic [ADDR_W-1:0] w_base;
    logic [ADDR_W-1:0] w_addr;
    logic w_push;
    logic fifo_ready;

    assign w_start = k_rise & w_go_ff; // [R11]
    assign w_beat = w_start | (w_act_ff & (k_rise | kn_rise)); // [R4]
    assign w_idx = w_start ? dsb_pkg::FIRST_BEAT : w_cnt_ff;
    assign w_base = w_start ? w_load_ff : w_base_ff;
    assign w_addr = {w_base[ADDR_W-1:2], w_base[1:0] + w_idx}; // [R5] [R10]
    // a beat with both masks high is dropped here and never queued
    assign w_push = w_beat & ~(I_LANE0_WRITE_MASK_N & I_LANE1_WRITE_MASK_N); // [R2]

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            w_go_ff <= 1'b0;
            w_act_ff <= 1'b0;
            w_cnt_ff <= dsb_pkg::FIRST_BEAT;
            w_load_ff <= '0;
            w_base_ff <= '0;
        end else begin
            if (k_rise) begin
                w_go_ff <= load_wr;
            end
            if (load_wr) begin
                w_load_ff <= I_ADDR;
            end
            if (w_start) begin
                w_act_ff <= 1'b1;
                w_base_ff <= w_load_ff;
                w_cnt_ff <= dsb_pkg::SECOND_BEAT;
            end else if (w_beat) begin
                w_cnt_ff <= w_cnt_ff + 1'b1; // [R5]
                if (w_cnt_ff == dsb_pkg::LAST_BEAT) begin
                    w_act_ff <= 1'b0; // [R6]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write buffer and array
    logic [FW-1:0] fifo_out;
    logic fifo_valid;
    logic drain;
    logic [ADDR_W-1:0] d_addr;
    logic [DQ_W-1:0] d_data;
    logic [LANES-1:0] d_mask_n;
    logic [DQ_W-1:0] mem_ff [2**ADDR_W];
    logic r_act_ff;
    logic r_arm_ff;
    logic [DQ_W-1:0] lane_en;

    assign O_WRITE_READY = fifo_ready;
    // reads own the array; the buffer stalls until the read burst is over
    assign drain = ~(r_act_ff | r_arm_ff);
    assign {d_addr, d_data, d_mask_n} = fifo_out;

    dsb_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) i_dsb_fifo (
        .I_CLK(I_CLK),
        .I_RESET(I_RESET),
        .i_valid(w_push),
        .o_ready(fifo_ready),
        .i_data({w_addr, I_DQ, I_LANE1_WRITE_MASK_N, I_LANE0_WRITE_MASK_N}), // [R3]
        .o_valid(fifo_valid),
        .i_ready(drain),
        .o_data(fifo_out)
    );

    // one process owns the array; the lanes only shape its bit enable
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign lane_en[g*LANE_W +: LANE_W] = {LANE_W{~d_mask_n[g]}}; // [R1] [R2]
    end

    always_ff @(posedge I_CLK) begin
        if (fifo_valid && drain) begin
            mem_ff[d_addr] <= (mem_ff[d_addr] & ~lane_en) | (d_data & lane_en); // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read beat engine
    logic r_go_ff;
    logic [1:0] r_cnt_ff;
    logic [ADDR_W-1:0] r_load_ff;
    logic [ADDR_W-1:0] r_base_ff;
    logic r_start;
    logic r_beat;
    logic [1:0] r_idx;
    logic [ADDR_W-1:0] r_base;
    logic [ADDR_W-1:0] r_addr;
    logic [DQ_W-1:0] dq_ff;
    logic oe_ff;

    // first beat waits for the complementary edge after the next true clock
    assign r_start = r_arm_ff & oc_rise; // [R12]
    assign r_beat = r_start | (r_act_ff & (ot_rise | oc_rise)); // [R12]
    // a back-to-back load lands mid-burst, so the running base is kept apart
    assign r_idx = r_start ? dsb_pkg::FIRST_BEAT : r_cnt_ff;
    assign r_base = r_start ? r_load_ff : r_base_ff;
    assign r_addr = {r_base[ADDR_W-1:2], r_base[1:0] + r_idx}; // [R5] [R10]
    assign O_DQ = dq_ff;
    assign O_DQ_OE = oe_ff;

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            r_go_ff <= 1'b0;
            r_arm_ff <= 1'b0;
            r_act_ff <= 1'b0;
            r_cnt_ff <= dsb_pkg::FIRST_BEAT;
            r_load_ff <= '0;
            r_base_ff <= '0;
        end else begin
            if (load_rd) begin
                r_go_ff <= 1'b1;
                r_load_ff <= I_ADDR;
            end else if (k_rise && r_go_ff) begin
                r_go_ff <= 1'b0;
                r_arm_ff <= 1'b1;
            end
            if (r_start) begin
                r_arm_ff <= 1'b0;
                r_act_ff <= 1'b1;
                r_base_ff <= r_load_ff;
                r_cnt_ff <= dsb_pkg::SECOND_BEAT;
            end else if (r_beat) begin
                r_cnt_ff <= r_cnt_ff + 1'b1;
                if (r_cnt_ff == dsb_pkg::LAST_BEAT) begin
                    r_act_ff <= 1'b0; // [R6]
                end
            end
        end
    end

    // bus is released at the first output edge that carries no beat
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            dq_ff <= '0;
            oe_ff <= 1'b0;
        end else if (r_beat) begin
            dq_ff <= mem_ff[r_addr]; // [R12]
            oe_ff <= 1'b1;
        end else if (ot_rise || oc_rise) begin
            oe_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### dsb_ctrl_model.sv
// clock-pin model of the memory controller facing the core
`timescale 1ns/1ns
`default_nettype none
module dsb_ctrl_model (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // both output clocks held high
    input wire logic i_bypass,
    // clock pins and phase
    output logic o_k,
    output logic o_k_n,
    output logic o_c,
    output logic o_c_n,
    output logic [2:0] o_phase
);
    logic k_dly_ff;
    // eight system cycles a period so the sampler sees every pin edge
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_phase <= 3'h0;
            k_dly_ff <= 1'b1;
        end else begin
            o_phase <= o_phase + 3'h1;
            k_dly_ff <= o_k;
        end
    end
    assign o_k = !o_phase[2];
    assign o_k_n = o_phase[2];
    // output clocks trail the input clocks by a cycle, so the two timings differ
    assign o_c = i_bypass | k_dly_ff;
    assign o_c_n = i_bypass | !k_dly_ff;
endmodule
`default_nettype wire

// ### dsb_sram_core_sva.sv
// port assertions for the burst sram core
`timescale 1ns/1ns
`default_nettype none
module dsb_sram_core_chk (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // watched pins
    input wire logic I_K,
    input wire logic I_K_N,
    input wire logic I_C,
    input wire logic I_C_N,
    input wire logic I_CYCLE_LOAD_N,
    input wire logic I_READ_WRITE,
    input wire logic [dsb_pkg::DQ_W-1:0] O_DQ,
    input wire logic O_DQ_OE,
    input wire logic O_WRITE_READY
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    logic [3:0] pin_q;
    logic busy1_ff;
    logic [6:0] rd_age_ff;
    logic k_rise, kn_rise, out_rise, taken;
    assign k_rise = I_K && !pin_q[0];
    assign kn_rise = I_K_N && !pin_q[1];
    // both output clocks high hands timing back to the input clocks
    assign out_rise = (I_C && I_C_N) ? (k_rise || kn_rise)
        : ((I_C && !pin_q[2]) || (I_C_N && !pin_q[3]));
    assign taken = k_rise && !I_CYCLE_LOAD_N && !busy1_ff;
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            pin_q <= 4'hF;
            busy1_ff <= 1'b0;
            rd_age_ff <= 7'h7F;
        end else begin
            pin_q <= {I_C_N, I_C, I_K_N, I_K};
            busy1_ff <= k_rise ? taken : busy1_ff;
            if (taken && I_READ_WRITE) begin
                rd_age_ff <= 7'h00;
            end else if (rd_age_ff != 7'h7F) begin
                rd_age_ff <= rd_age_ff + 7'h01;
            end
        end
    end
    reset_idle_a: assert property ($fell(I_RESET) |-> !O_DQ_OE && O_WRITE_READY)
        else $error("outputs busy after reset");
    oe_after_load_a: assert property ($rose(O_DQ_OE) |-> rd_age_ff inside {[1:40]})
        else $error("drive without read load");
    write_quiet_a: assert property (taken && !I_READ_WRITE && !O_DQ_OE |=> !O_DQ_OE [*4])
        else $error("drive on write");
    idle_release_a: assert property (rd_age_ff > 7'h3C |-> !O_DQ_OE)
        else $error("bus held after burst");
    oe_holds_a: assert property ($rose(O_DQ_OE) |-> O_DQ_OE [*8])
        else $error("read burst cut short");
    dq_on_clock_a: assert property (O_DQ_OE && !$stable(O_DQ) |-> $past(out_rise))
        else $error("read data off clock");
    oe_off_clock_a: assert property ($fell(O_DQ_OE) |-> $past(out_rise))
        else $error("release off clock");
    // a wrongly taken read would start driving only after more than eight cycles
    load_ignored_a: assert property (k_rise && !I_CYCLE_LOAD_N && busy1_ff
        && rd_age_ff > 7'h3C |=> !O_DQ_OE [*8] ##1 !O_DQ_OE [*8])
        else $error("early load taken");
    cover property (taken && I_READ_WRITE && I_C && I_C_N);
    cover property (taken && !I_READ_WRITE);
    cover property (k_rise && !I_CYCLE_LOAD_N && busy1_ff);
endmodule
bind dsb_sram_core dsb_sram_core_chk i_dsb_sram_core_chk (.I_CLK(I_CLK), .I_RESET(I_RESET),
    .I_K(I_K), .I_K_N(I_K_N), .I_C(I_C), .I_C_N(I_C_N), .I_CYCLE_LOAD_N(I_CYCLE_LOAD_N),
    .I_READ_WRITE(I_READ_WRITE), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_WRITE_READY(O_WRITE_READY));
`default_nettype wire

// ### dsb_sram_core_test.sv
// self-checking bench for the burst sram core
`timescale 1ns/1ns
`default_nettype none
module dsb_sram_core_test;
    localparam int AW = 6;
    logic clk = 1'b0, rst = 1'b1, byp = 1'b0, ld_n = 1'b1, rw = 1'b0, oe, rdy, k, kn, c, cn;
    logic [AW-1:0] addr = '0;
    logic [1:0] msk = 2'h3;
    logic [2:0] ph;
    logic [17:0] dq = '0, q;
    logic [17:0] mem [64];
    logic [17:0] exp_q [$];
    logic [31:0] seed = 32'h6be74304;
    int err_count = 0, n_checks = 0;
    always #5 clk = ~clk;
    dsb_ctrl_model i_dsb_ctrl_model (.I_CLK(clk), .I_RESET(rst), .i_bypass(byp), .o_k(k),
        .o_k_n(kn), .o_c(c), .o_c_n(cn), .o_phase(ph));
    dsb_sram_core #(.ADDR_W(AW)) i_dsb_sram_core (.I_CLK(clk), .I_RESET(rst), .I_K(k),
        .I_K_N(kn), .I_C(c), .I_C_N(cn), .I_CYCLE_LOAD_N(ld_n), .I_READ_WRITE(rw),
        .I_ADDR(addr), .I_LANE0_WRITE_MASK_N(msk[0]), .I_LANE1_WRITE_MASK_N(msk[1]),
        .I_DQ(dq), .O_DQ(q), .O_DQ_OE(oe), .O_WRITE_READY(rdy));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        n_checks++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic at_phase(input logic [2:0] p);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ph !== p && i < 20);
        if (ph !== p) begin
            err_count++;
            print_verdict();
        end
    endtask
    task automatic wr_burst(input logic [AW-1:0] a, input logic [7:0] m, input logic bad);
        logic [17:0] d;
        logic [AW-1:0] wa;
        int i;
        at_phase(3'h6);
        ld_n <= 1'b0;
        rw <= 1'b0;
        addr <= a;
        for (i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            d = seed[17:0];
            wa = {a[AW-1:2], a[1:0] + i[1:0]};
            at_phase(i[0] ? 3'h2 : 3'h6);
            // a read load here falls in the burst's first clock and must be dropped
            ld_n <= !(bad && i == 0);
            rw <= 1'b1;
            dq <= d;
            msk <= m[2*i+:2];
            if (!m[2*i]) mem[wa][8:0] = d[8:0];
            if (!m[2*i+1]) mem[wa][17:9] = d[17:9];
        end
        at_phase(3'h6);
        ld_n <= 1'b1;
        dq <= ~d;
        msk <= seed[1:0];
    endtask
    task automatic rd_burst(input logic [AW-1:0] a);
        int i;
        at_phase(3'h6);
        ld_n <= 1'b0;
        rw <= 1'b1;
        addr <= a;
        for (i = 0; i < 4; i++) exp_q.push_back(mem[{a[AW-1:2], a[1:0] + i[1:0]}]);
        at_phase(3'h6);
        ld_n <= 1'b1;
        addr <= ~a;
    endtask
    always @(posedge clk) begin
        if (!rst && ph[1:0] == 2'h2 && oe === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(q, exp_q.pop_front());
            end else begin
                check({17'h0, oe}, 18'h0);
            end
        end
    end
    initial begin
        int i;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({16'h0, oe, rdy}, 18'h1);
        for (i = 0; i < 16; i++) wr_burst({i[3:0], i[1:0]}, 8'h00, 1'b0);
        wr_burst(6'h05, 8'h1B, 1'b1);
        wr_burst(6'h2A, 8'hE4, 1'b0);
        // reads of still-buffered words return old contents, so let it drain
        repeat (60) @(posedge clk);
        check({17'h0, rdy}, 18'h1);
        for (i = 0; i < 16; i++) rd_burst({i[3:0], ~i[1:0]});
        repeat (40) @(posedge clk);
        byp <= 1'b1;
        rd_burst(6'h07);
        repeat (40) @(posedge clk);
        byp <= 1'b0;
        check({17'h0, oe}, 18'h0);
        check(18'(exp_q.size()), 18'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
